// [hdl/sem_pkg.sv]
package sem_pkg;
   localparam int CLK_MHZ = 25;
   localparam int EDGE_SPACE_NS = 200;
   localparam int EDGE_SPACE_CYC = (EDGE_SPACE_NS * CLK_MHZ + 999) / 1000;
   localparam int TOUT_SHORT_NS = 1300;
   localparam int TOUT_LONG_NS = 10000;
   localparam int TOUT_SHORT_CYC = (TOUT_SHORT_NS * CLK_MHZ + 999) / 1000;
   localparam int TOUT_LONG_CYC = (TOUT_LONG_NS * CLK_MHZ + 999) / 1000;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int POS_W = 16;
   localparam int TURN_W = 16;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_LINES = 8'h04;
   localparam logic [7:0] REG_IDXOFF = 8'h08;
   localparam logic [7:0] REG_INTERP = 8'h0c;
   localparam logic [7:0] REG_POSITION = 8'h10;
   localparam logic [7:0] REG_EDGES = 8'h14;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_GRAY_BIT = 2;
   localparam int CTRL_DIRINV_BIT = 3;
   localparam int CTRL_TOUT_BIT = 4;
   localparam int CTRL_ENCFB_BIT = 5;
   localparam int CTRL_TURN_LSB = 8;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_PLAIN = 2'h1;
   localparam logic [1:0] MODE_SSI = 2'h2;
   localparam logic [1:0] MODE_INTERP = 2'h3;
   localparam logic [1:0] MODE_RST = MODE_PLAIN;
   localparam logic [4:0] TURN_MIN = 5'h0c;
   localparam logic [4:0] TURN_MAX = 5'h10;
   localparam logic [4:0] TURN_RST = 5'h0c;
   localparam logic [19:0] LINES_MIN = 20'h00100;
   localparam logic [19:0] LINES_MAX_RES = 20'h01000;
   localparam logic [19:0] LINES_MAX_ENC = 20'h80000;
   localparam logic [19:0] LINES_RST = 20'h00400;
   localparam logic [18:0] IDXOFF_RST = 19'h00000;
   localparam logic [2:0] INTERP_MIN = 3'h2;
   localparam logic [2:0] INTERP_MAX = 3'h7;
   localparam logic [2:0] INTERP_RST = 3'h2;
   localparam logic [1:0] QUAD_INDEX_PHASE = 2'h2;

   function automatic logic [31:0] sem_gray(input logic [31:0] bin);
      sem_gray = bin ^ (bin >> 1);
   endfunction : sem_gray
endpackage : sem_pkg

// [hdl/sem_quad_if.sv]
`timescale 1ns/1ps
interface sem_quad_if #(parameter int EW = 29);
   logic tick;
   logic [EW-1:0] total;
   logic [EW-1:0] target;
   logic [EW-1:0] cur;
   modport ctl(output tick, output total, output target, input cur);
   modport gen(input tick, input total, input target, output cur);
endinterface : sem_quad_if

// [hdl/sem_quad_gen.sv]
`timescale 1ns/1ps
module sem_quad_gen
   import sem_pkg::*;
#(
   parameter int EW = 29
)(
   input wire logic clk,
   input wire logic rst_n,
   sem_quad_if.gen q
);
   logic [EW-1:0] half;
   logic stepUp;
   logic stepDn;

   // Shortest way round the circle toward the target
   always_comb begin
      half = q.total >> 1;
      stepUp = 1'b0;
      stepDn = 1'b0;
      if (q.target != q.cur) begin
         if (q.target > q.cur) begin
            stepUp = (q.target - q.cur) <= half;
            stepDn = !stepUp;
         end else begin
            stepDn = (q.cur - q.target) <= half;
            stepUp = !stepDn;
         end
      end
   end

   // One edge per tick at most
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q.cur <= '0;
      end else if (q.cur >= q.total) begin
         q.cur <= '0;
      end else if (q.tick && stepUp) begin // RULE2 RULE15
         q.cur <= (q.cur == q.total - 1'b1) ? '0 : q.cur + 1'b1;
      end else if (q.tick && stepDn) begin // RULE2 RULE15
         q.cur <= (q.cur == '0) ? q.total - 1'b1 : q.cur - 1'b1;
      end
   end
endmodule : sem_quad_gen

// [hdl/sem_ssi_link.sv]
`timescale 1ns/1ps
module sem_ssi_link
   import sem_pkg::*;
(
   input wire logic sclk,
   input wire logic rst_n,
   input wire logic [31:0] pubWord,
   input wire logic [5:0] pubLen,
   input wire logic pubReq,
   input wire logic lineIdle,
   output logic pubAck,
   output logic bitOut
);
   logic rstS1, rstS2;
   logic reqS1, reqS2;
   logic [31:0] holdWord;
   logic [5:0] holdLen;
   logic [31:0] frameWord;
   logic [5:0] frameLen;
   logic [5:0] bitIdx;

   // Falling edge: reset and handshake sync, frame latch
   always_ff @(negedge sclk) begin
      rstS1 <= rst_n;
      rstS2 <= rstS1;
      reqS1 <= pubReq;
      reqS2 <= reqS1;
   end

   always_ff @(negedge sclk) begin
      if (!rstS2) begin
         pubAck <= 1'b0;
         holdWord <= '0;
         holdLen <= 6'h1c;
      end else if (reqS2 != pubAck) begin
         holdWord <= pubWord;
         holdLen <= pubLen;
         pubAck <= reqS2;
      end
   end

   always_ff @(negedge sclk) begin
      if (!rstS2) begin
         frameWord <= '0;
         frameLen <= 6'h1c;
      end else if (bitIdx == 6'h00) begin // RULE14
         frameWord <= holdWord;
         frameLen <= holdLen;
      end
   end

   // Rising edge: one bit out, most significant first
   // Idle line restarts the word, so a cut frame cannot skew the next read
   always_ff @(posedge sclk or posedge lineIdle) begin
      if (lineIdle) begin // RULE13
         bitIdx <= '0;
         bitOut <= 1'b1;
      end else if (!rstS2) begin
         bitIdx <= '0;
         bitOut <= 1'b1;
      end else if (bitIdx < frameLen) begin // RULE9 RULE14
         bitOut <= frameWord[5'(frameLen - bitIdx - 6'h01)];
         bitIdx <= bitIdx + 6'h01;
      end else begin
         bitOut <= 1'b0;
         bitIdx <= '0;
      end
   end

   AST_BIT_INDEX: assert property (@(posedge sclk) disable iff (!rstS2)
      bitIdx <= 6'h20) else $error("Serial bit index beyond word"); // RULE9
endmodule : sem_ssi_link

// [hdl/sem_top.sv]
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Mode field selects plain, interpolated or serial; only that output is enabled
// RULE2 - Plain mode turns shaft angle changes into quadrature steps following motion
// RULE3 - Two channels a quarter period apart; leading channel shows direction
// RULE4 - Plain mode: one index pulse per turn, only while both channels high
// RULE5 - Lines per turn 256..4096 with resolver, up to 2^19 with encoder
// RULE6 - Interpolated: encoder lines times 4..128; index passed through from encoder
// RULE7 - Stored index offset sets index position within the turn
// RULE8 - Count and serial value rise for clockwise rotation by default
// RULE9 - Serial mode shifts out a word of at most 32 bits per read
// RULE10 - Serial word leads with turn count, 12..16 bits configurable
// RULE11 - Then a fixed 16-bit in-turn position, independent of turn width
// RULE12 - Serial word sent Gray coded or binary as configured
// RULE13 - Serial timing 1.3 us or 10 us, also the idle timeout before a new read
// RULE14 - Reader starts with clock low; word latched then, MSB first, held till timeout
// RULE15 - At most one channel transition per update keeps edge spacing
module sem_top
   import sem_pkg::*;
#(
   parameter int EW = 29
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [POS_W-1:0] shaftAngle,
   input wire logic encIdxPin,
   input wire logic sclk,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdData,
   output logic quadA,
   output logic quadB,
   output logic index_marker_pulse,
   output logic quadOe,
   output logic ssiData,
   output logic ssiOe
);
   generate
      if (EW < 29) begin : gCheck
         $error("EW too narrow for the largest line count");
      end
   endgenerate

   function automatic logic [19:0] clampU(input logic [19:0] v, input logic [19:0] lo,
                                          input logic [19:0] hi);
      clampU = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clampU

   sem_quad_if #(.EW(EW)) quadBus();

   // Control registers
   logic [1:0] emulation_function_select_reg;
   logic grayReg;
   logic dirInvReg;
   logic toutLongReg;
   logic encFbReg;
   logic [4:0] turn_field_width_reg;
   logic [19:0] linesReg;
   logic [18:0] index_position_offset_reg;
   logic [2:0] interpReg;
   logic [19:0] linesMax;

   assign linesMax = encFbReg ? LINES_MAX_ENC : LINES_MAX_RES;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         emulation_function_select_reg <= MODE_RST;
         grayReg <= 1'b0;
         dirInvReg <= 1'b0;
         toutLongReg <= 1'b0;
         encFbReg <= 1'b0;
         turn_field_width_reg <= TURN_RST;
      end else if (regWr && regAddr == REG_CTRL) begin
         emulation_function_select_reg <= regWrData[CTRL_MODE_LSB +: 2]; // RULE1
         grayReg <= regWrData[CTRL_GRAY_BIT]; // RULE12
         dirInvReg <= regWrData[CTRL_DIRINV_BIT]; // RULE8
         toutLongReg <= regWrData[CTRL_TOUT_BIT]; // RULE13
         encFbReg <= regWrData[CTRL_ENCFB_BIT];
         turn_field_width_reg <= 5'(clampU({15'h0, regWrData[CTRL_TURN_LSB +: 5]},
                                           {15'h0, TURN_MIN}, {15'h0, TURN_MAX})); // RULE10
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         linesReg <= LINES_RST;
      end else if (regWr && regAddr == REG_LINES) begin
         linesReg <= clampU(regWrData[19:0], LINES_MIN, linesMax); // RULE5
      end else if (linesReg > linesMax) begin
         linesReg <= linesMax; // RULE5
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         index_position_offset_reg <= IDXOFF_RST;
      end else if (regWr && regAddr == REG_IDXOFF) begin
         index_position_offset_reg <= regWrData[18:0]; // RULE7
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         interpReg <= INTERP_RST;
      end else if (regWr && regAddr == REG_INTERP) begin
         interpReg <= 3'(clampU({17'h0, regWrData[2:0]}, {17'h0, INTERP_MIN},
                                {17'h0, INTERP_MAX})); // RULE6
      end
   end

   // Shaft angle, direction and turn counting
   logic [POS_W-1:0] angleReg;
   logic [TURN_W-1:0] turnReg;
   logic modePlain, modeInterp, modeSsi;

   assign modePlain = emulation_function_select_reg == MODE_PLAIN;
   assign modeInterp = emulation_function_select_reg == MODE_INTERP;
   assign modeSsi = emulation_function_select_reg == MODE_SSI;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         angleReg <= '0;
      end else begin
         angleReg <= dirInvReg ? ~shaftAngle : shaftAngle; // RULE8
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         turnReg <= '0;
      end else if (angleReg[POS_W-1 -: 2] == 2'b11 && shaftAngle[POS_W-1 -: 2] == 2'b00
                   && !dirInvReg) begin
         turnReg <= turnReg + 1'b1; // RULE8
      end else if (angleReg[POS_W-1 -: 2] == 2'b00 && shaftAngle[POS_W-1 -: 2] == 2'b11
                   && !dirInvReg) begin
         turnReg <= turnReg - 1'b1;
      end else if (angleReg[POS_W-1 -: 2] == 2'b11 && shaftAngle[POS_W-1 -: 2] == 2'b11
                   && dirInvReg) begin
         turnReg <= turnReg + 1'b1;
      end else if (angleReg[POS_W-1 -: 2] == 2'b00 && shaftAngle[POS_W-1 -: 2] == 2'b00
                   && dirInvReg) begin
         turnReg <= turnReg - 1'b1;
      end
   end

   // Quadrature target and update tick
   logic [EW-1:0] totalReg;
   logic [EW-1:0] targetReg;
   logic [EW+POS_W-1:0] product;
   logic [2:0] tickCnt;

   assign product = angleReg * totalReg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         totalReg <= EW'({LINES_RST, 2'b00});
         targetReg <= '0;
      end else begin
         totalReg <= EW'({linesReg, 2'b00}) << (modeInterp ? interpReg : 3'h0); // RULE6
         targetReg <= product[EW+POS_W-1 -: EW]; // RULE2
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || tickCnt == 3'(EDGE_SPACE_CYC - 1)) begin
         tickCnt <= '0;
      end else begin
         tickCnt <= tickCnt + 3'h1;
      end
   end

   assign quadBus.tick = tickCnt == 3'(EDGE_SPACE_CYC - 1); // RULE15
   assign quadBus.total = totalReg;
   assign quadBus.target = targetReg;

   sem_quad_gen #(.EW(EW)) uQuad (
      .clk(clk),
      .rst_n(rst_n),
      .q(quadBus)
   );

   // Encoder index pin synchroniser
   logic encIdxS1, encIdxS2;
   logic [EW-1:0] idxEdge;

   always_ff @(posedge clk) begin
      encIdxS1 <= encIdxPin;
      encIdxS2 <= encIdxS1;
   end

   assign idxEdge = EW'({index_position_offset_reg, QUAD_INDEX_PHASE});

   // Quadrature outputs: B leads A when counting up
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         quadA <= 1'b0;
         quadB <= 1'b0;
         index_marker_pulse <= 1'b0;
         quadOe <= 1'b0;
      end else begin
         quadOe <= modePlain || modeInterp; // RULE1
         quadA <= (modePlain || modeInterp) && quadBus.cur[1]; // RULE3
         quadB <= (modePlain || modeInterp) && (quadBus.cur[1] ^ quadBus.cur[0]); // RULE3
         if (modePlain) begin
            index_marker_pulse <= quadBus.cur == idxEdge; // RULE4 RULE7
         end else if (modeInterp) begin
            index_marker_pulse <= encIdxS2; // RULE6
         end else begin
            index_marker_pulse <= 1'b0;
         end
      end
   end

   // Serial word build and handshake toward the link domain
   logic [31:0] wordBin;
   logic [5:0] wordLen;
   logic [31:0] pubWord;
   logic [5:0] pubLen;
   logic pubReq;
   logic ackS1, ackS2;
   logic linkAck;
   logic linkBit;
   logic linkIdle;

   assign wordBin = ({16'h0, turnReg} & ~(32'hffff_ffff << turn_field_width_reg))
                    << POS_W | {16'h0, angleReg}; // RULE10 RULE11
   assign wordLen = 6'(turn_field_width_reg) + 6'(POS_W); // RULE9

   always_ff @(posedge clk) begin
      ackS1 <= linkAck;
      ackS2 <= ackS1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pubWord <= '0;
         pubLen <= 6'(TURN_RST) + 6'(POS_W);
         pubReq <= 1'b0;
      end else if (ackS2 == pubReq) begin
         pubWord <= grayReg ? sem_gray(wordBin) : wordBin; // RULE12
         pubLen <= wordLen;
         pubReq <= !pubReq;
      end
   end

   sem_ssi_link uLink (
      .sclk(sclk),
      .rst_n(rst_n),
      .pubWord(pubWord),
      .pubLen(pubLen),
      .pubReq(pubReq),
      .lineIdle(linkIdle),
      .pubAck(linkAck),
      .bitOut(linkBit)
   );

   // Serial clock activity and idle timeout
   logic sclkS1, sclkS2, sclkS3;
   logic bitS1, bitS2;
   logic [7:0] serial_idle_timeout;
   logic sclkEdge;

   always_ff @(posedge clk) begin
      sclkS1 <= sclk;
      sclkS2 <= sclkS1;
      sclkS3 <= sclkS2;
      bitS1 <= linkBit;
      bitS2 <= bitS1;
   end

   assign sclkEdge = sclkS2 != sclkS3;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         serial_idle_timeout <= '0;
      end else if (sclkEdge) begin
         serial_idle_timeout <= toutLongReg ? 8'(TOUT_LONG_CYC) : 8'(TOUT_SHORT_CYC); // RULE13
      end else if (serial_idle_timeout != 8'h00) begin
         serial_idle_timeout <= serial_idle_timeout - 8'h01;
      end
   end

   // Link held at word start while idle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         linkIdle <= 1'b1;
      end else begin
         linkIdle <= serial_idle_timeout == 8'h00; // RULE13
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ssiData <= 1'b1;
         ssiOe <= 1'b0;
      end else begin
         ssiOe <= modeSsi; // RULE1
         ssiData <= !modeSsi || serial_idle_timeout == 8'h00 || bitS2; // RULE13 RULE14
      end
   end

   // Register read port
   always_ff @(posedge clk) begin
      if (!rst_n || !regRd) begin
         regRdData <= '0;
      end else begin
         unique case (regAddr)
            REG_CTRL: regRdData <= {19'h0, turn_field_width_reg, 2'b00, encFbReg,
                                    toutLongReg, dirInvReg, grayReg,
                                    emulation_function_select_reg};
            REG_LINES: regRdData <= {12'h0, linesReg};
            REG_IDXOFF: regRdData <= {13'h0, index_position_offset_reg};
            REG_INTERP: regRdData <= {29'h0, interpReg};
            REG_POSITION: regRdData <= {turnReg, angleReg};
            REG_EDGES: regRdData <= 32'(quadBus.cur);
            default: regRdData <= '0;
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence sclkActive;
      sclkEdge;
   endsequence

   sequence idleReached;
      serial_idle_timeout == 8'h00 && modeSsi;
   endsequence

   AST_MODE_EXCLUSIVE: assert property ( // RULE1
      modeSsi |=> !quadOe && ssiOe) else $error("Quadrature driven in serial mode");
   AST_ONE_CHANNEL: assert property ( // RULE3
      (quadOe && $past(quadOe) && $changed(quadA)) |-> $stable(quadB))
      else $error("Both channels moved together");
   AST_EDGE_SPACING: assert property ( // RULE15
      (quadOe && ($changed(quadA) || $changed(quadB)))
      |=> (!quadOe || ($stable(quadA) && $stable(quadB)))[*4])
      else $error("Quadrature edges too close");
   AST_INDEX_AB: assert property ( // RULE4
      (index_marker_pulse && $past(modePlain)) |-> quadA && quadB)
      else $error("Index outside A=B=1");
   AST_INTERP_IDX: assert property ( // RULE6
      (modeInterp && $past(modeInterp)) |-> index_marker_pulse == $past(encIdxS2))
      else $error("Encoder index not passed through");
   AST_LINES_RANGE: assert property ( // RULE5
      $rose(regWr && regAddr == REG_LINES) |=> linesReg >= LINES_MIN && linesReg <= linesMax)
      else $error("Line count out of range");
   AST_TURN_WIDTH: assert property ( // RULE10
      turn_field_width_reg >= TURN_MIN && turn_field_width_reg <= TURN_MAX)
      else $error("Turn field width out of range");
   AST_TIMEOUT_LOAD: assert property ( // RULE13
      sclkActive |=> serial_idle_timeout == (toutLongReg ? 8'(TOUT_LONG_CYC)
                                                         : 8'(TOUT_SHORT_CYC)))
      else $error("Idle timeout not reloaded");
   AST_IDLE_HIGH: assert property ( // RULE14
      idleReached ##1 modeSsi |-> ssiData) else $error("Serial data not idle high");
   AST_GRAY_WORD: assert property ( // RULE12
      (ackS2 == pubReq) |=> pubWord == ($past(grayReg) ? sem_gray($past(wordBin))
                                                        : $past(wordBin)))
      else $error("Published word coding wrong");
   AST_TURN_UP: assert property ( // RULE8
      (!dirInvReg && angleReg[POS_W-1 -: 2] == 2'b11 && shaftAngle[POS_W-1 -: 2] == 2'b00)
      |=> turnReg == $past(turnReg) + 1'b1) else $error("Turn count not rising");
endmodule : sem_top

// [verification/sem_ssi_reader.sv]
`timescale 1ns/1ps
module sem_ssi_reader (
   output logic sclk,
   input wire logic ssiData
);
   initial sclk = 1'b1;

   // One read: clock low latches, then len+1 rising edges, bits sampled high phase
   task automatic read_frame(input int len, input int hp, output logic [31:0] word,
         output logic tail);
      int i;
      word = 32'h00000000;
      tail = 1'b1;
      sclk = 1'b0;
      #(24 * hp);
      for (i = 0; i <= len; i++) begin
         sclk = 1'b1;
         #(24 * hp);
         if (i < len) begin
            word = {word[30:0], ssiData};
            sclk = 1'b0;
            #(24 * hp);
         end else begin
            tail = ssiData;
         end
      end
   endtask : read_frame

   // Clock held high until the idle timeout has run out
   task automatic rest(input int ns);
      sclk = 1'b1;
      #(ns);
   endtask : rest
endmodule : sem_ssi_reader

// [verification/shaft_encoder_emulation_tb_top.sv]
`timescale 1ns/1ps
module shaft_encoder_emulation_tb_top
   import sem_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] shaftAngle = 16'h0000;
   logic encIdxPin = 1'b0;
   logic sclk;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h00000000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdData;
   logic quadA, quadB, idxMark, quadOe, ssiData, ssiOe;
   int seed = 80380;
   int err_total = 0;
   int cmp_count = 0;
   int gap = 100;
   int idxRises = 0;
   logic plainMode = 1'b0;
   logic prevA = 1'b0, prevB = 1'b0, prevIdx = 1'b0;
   logic [31:0] w, e, v;
   logic t;
   logic [15:0] a;
   int n, wd;
   logic [7:0] tAddr [8];
   logic [31:0] tWr [8], tExp [8];

   always #20 clk = ~clk;

   sem_top dut_u (.clk(clk), .rst_n(rst_n), .shaftAngle(shaftAngle), .encIdxPin(encIdxPin),
      .sclk(sclk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .quadA(quadA), .quadB(quadB), .index_marker_pulse(idxMark),
      .quadOe(quadOe), .ssiData(ssiData), .ssiOe(ssiOe));
   sem_ssi_reader rdr_u (.sclk(sclk), .ssiData(ssiData));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic after(input int cyc);
      repeat (cyc) @(posedge clk);
      #1;
   endtask : after

   task automatic reg_wr(input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk);
      regAddr <= adr;
      regWrData <= dat;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : reg_wr

   task automatic reg_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
      @(posedge clk);
      regAddr <= adr;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      check(what, regRdData, exp);
   endtask : reg_chk

   task automatic set_angle(input logic [15:0] ang);
      @(posedge clk);
      shaftAngle <= ang;
   endtask : set_angle

   task automatic do_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      fork
         repeat (20) @(posedge clk);
         rdr_u.read_frame(4, 1, w, t);
      join
      rst_n <= 1'b1;
      after(2);
   endtask : do_reset

   function automatic logic [31:0] ctrl_word(input logic [1:0] md, input logic gr,
         input logic dinv, input logic tlong, input logic enc, input logic [4:0] tw);
      return {19'h00000, tw, 2'h0, enc, tlong, dinv, gr, md};
   endfunction : ctrl_word

   function automatic logic [1:0] quad_state(input int k);
      return {k[1], k[1] ^ k[0]};
   endfunction : quad_state

   // Quadrature watch: single-channel steps, spacing, index phase
   always @(posedge clk) begin
      if (rst_n === 1'b1 && quadOe === 1'b1) begin
         if ({quadA, quadB} !== {prevA, prevB}) begin
            check("edge step", {31'h0, ((quadA ^ prevA) & (quadB ^ prevB)) | (gap < 5)}, 32'h0);
            gap = 1;
         end else begin
            gap++;
         end
         if (plainMode && idxMark === 1'b1) check("index phase", {30'h0, quadA, quadB}, 32'h3);
         if (plainMode && idxMark === 1'b1 && prevIdx !== 1'b1) idxRises++;
      end else begin
         gap = 100;
      end
      prevA = quadA;
      prevB = quadB;
      prevIdx = idxMark;
   end

   initial begin
      #3000000;
      err_total++;
      wrap_up();
   end

   initial begin
      tAddr = '{REG_CTRL, REG_CTRL, REG_LINES, REG_LINES, REG_INTERP, REG_INTERP, REG_CTRL,
         REG_LINES};
      tWr = '{32'h00001f01, 32'h00000501, 32'h00000010, 32'h000fffff, 32'h00000000,
         32'h00000007, 32'h00000e21, 32'h000fffff};
      tExp = '{32'h00001001, 32'h00000c01, 32'h00000100, 32'h00001000, 32'h00000002,
         32'h00000007, 32'h00000e21, 32'h00080000};
      do_reset();
      reg_chk("ctrl", REG_CTRL, 32'h00000c01);
      reg_chk("lines", REG_LINES, 32'h00000400);
      reg_chk("offset", REG_IDXOFF, 32'h00000000);
      reg_chk("interp", REG_INTERP, 32'h00000002);
      check("oe plain", {30'h0, quadOe, ssiOe}, 32'h2);
      reg_wr(8'h20, 32'hffffffff);
      reg_chk("unmapped", 8'h20, 32'h00000000);
      reg_wr(REG_POSITION, 32'hffffffff);
      reg_chk("read only", REG_POSITION, 32'h00000000);
      for (int i = 0; i < 8; i++) begin
         reg_wr(tAddr[i], tWr[i]);
         reg_chk("clamp", tAddr[i], tExp[i]);
      end
      repeat (4) begin
         v = 32'h00000100 + (($random(seed) & 32'h7fffffff) % 3841);
         reg_wr(REG_LINES, v);
         reg_chk("lines rnd", REG_LINES, v);
      end
      reg_wr(REG_CTRL, ctrl_word(MODE_PLAIN, 1'b0, 1'b0, 1'b0, 1'b0, 5'h0c));
      reg_wr(REG_LINES, 32'h00000100);
      reg_wr(REG_IDXOFF, 32'h00000003);
      plainMode = 1'b1;
      set_angle(16'h0580);
      after(400);
      check("index count", idxRises, 32'h1);
      reg_chk("edges", REG_EDGES, 32'd22);
      check("quad state", {30'h0, quadA, quadB}, {30'h0, quad_state(22)});
      repeat (3) begin
         a = 16'($random(seed)) & 16'h7fff;
         set_angle(a);
         after(3000);
         reg_chk("edges", REG_EDGES, {16'h0, a} >> 6);
         check("quad state", {30'h0, quadA, quadB}, {30'h0, quad_state(int'(a >> 6))});
         reg_chk("position", REG_POSITION, {16'h0, a});
      end
      reg_wr(REG_CTRL, ctrl_word(MODE_PLAIN, 1'b0, 1'b1, 1'b0, 1'b0, 5'h0c));
      after(3500);
      n = quadA ? (quadB ? 2 : 3) : (quadB ? 1 : 0);
      set_angle(a + 16'h0140);
      after(500);
      check("inverted", {30'h0, quadA, quadB}, {30'h0, quad_state(n - 5)});
      plainMode = 1'b0;
      reg_wr(REG_CTRL, ctrl_word(MODE_INTERP, 1'b0, 1'b0, 1'b0, 1'b1, 5'h0c));
      @(posedge clk);
      encIdxPin <= 1'b1;
      after(6);
      check("index through", {31'h0, idxMark}, 32'h1);
      check("oe interp", {30'h0, quadOe, ssiOe}, 32'h2);
      encIdxPin <= 1'b0;
      after(6);
      check("index through", {31'h0, idxMark}, 32'h0);
      reg_wr(REG_CTRL, ctrl_word(MODE_OFF, 1'b0, 1'b0, 1'b0, 1'b0, 5'h0c));
      after(3);
      check("oe off", {30'h0, quadOe, ssiOe}, 32'h0);
      set_angle(16'h0000);
      do_reset();
      set_angle(16'h6000);
      after(20);
      set_angle(16'hc000);
      after(20);
      a = 16'h2000 + (16'($random(seed)) & 16'h1fff);
      set_angle(a);
      after(20);
      for (int i = 0; i < 4; i++) begin
         wd = i[0] ? 16 : 12;
         reg_wr(REG_CTRL, ctrl_word(MODE_SSI, i[1], 1'b0, i[0], 1'b0, 5'(wd)));
         after(3);
         check("oe serial", {30'h0, quadOe, ssiOe}, 32'h1);
         e = 32'h00010000 | {16'h0, a};
         if (i[1]) e = e ^ (e >> 1);
         repeat (2) begin
            rdr_u.read_frame(wd + 16, 8, w, t);
            rdr_u.rest(12000);
         end
         check("idle high", {31'h0, ssiData}, 32'h1);
         rdr_u.read_frame(wd + 16, 8, w, t);
         check("ssi word", w, e);
         check("ssi tail", {31'h0, t}, 32'h0);
         after(i[0] ? 200 : 15);
         check("held low", {31'h0, ssiData}, 32'h0);
         after(i[0] ? 100 : 45);
         check("timed out", {31'h0, ssiData}, 32'h1);
      end
      wrap_up();
   end
endmodule : shaft_encoder_emulation_tb_top
